// >>> logic/sis_pkg.sv
// Purpose: shared constants and types for the servo input signal select block
// Assumes: registers reached over a plain address/strobe port, 16-bit data
// Notes: one selection per hex digit of each selection word
package sis_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int TRQ_W = 8;
  localparam logic [3:0] OFF_FUNC_SEL = 4'h0;
  localparam logic [3:0] OFF_SRC_SEL = 4'h1;
  localparam logic [3:0] OFF_LIMIT1 = 4'h2;
  localparam logic [3:0] OFF_LIMIT2 = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic [15:0] SEL_MASK = 16'h1111;
  localparam logic [7:0] RST_LIMIT = 8'h64;
  // digit positions (low bit of each nibble)
  localparam int FUNC_ACCEL2_POS = 0;
  localparam int SRC_TRQMODE_POS = 0;
  localparam int SRC_SERVO_POS = 4;
  localparam int SRC_FWD_POS = 8;
  localparam int SRC_REV_POS = 12;
  // status bit positions
  localparam int ST_SERVO = 0;
  localparam int ST_FWD = 1;
  localparam int ST_REV = 2;
  localparam int ST_ACCEL2 = 3;
  localparam int ST_TRQSEL = 4;

  typedef struct packed {
    logic servo_on_input;
    logic forward_limit_input;
    logic reverse_limit_input;
    logic torque_limit_switch;
    logic accel2_input;
  } sis_pins_type;

  typedef struct packed {
    logic trq_mode;
    logic servo_auto;
    logic fwd_auto;
    logic rev_auto;
  } sis_src_type;
endpackage

// >>> logic/sis_src_pick.sv
// Purpose: one discrete input resolved against its forced-on selection
// Assumes: inputs synchronous to CLK
// Notes: registered so the result comes from a flip-flop
module sis_src_pick (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic force_on,
  input wire logic pin,
  output logic state_ff
);
  logic nxt_state;
  assign nxt_state = force_on | pin;
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end
endmodule // sis_src_pick

// >>> logic/sis_torque_sel.sv
// Purpose: picks the torque limit in force from switch, mode and limits
// Assumes: all limits in the same percent scale
// Notes: in mode 0 a smaller-wins comparison guards against the switch raising the limit; in mode 1 the switch applies limit 2 even above limit 1
module sis_torque_sel #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic mode,
  input wire logic sw,
  input wire logic [W-1:0] ext_cmd,
  input wire logic [W-1:0] lim1,
  input wire logic [W-1:0] lim2,
  output logic [W-1:0] limit_ff,
  output logic [1:0] src_ff
);
  logic [W-1:0] nxt_limit;
  logic [1:0] nxt_src;
  // src: 0 limit1, 1 external command, 2 limit2
  always_comb begin
    nxt_limit = lim1;
    nxt_src = 2'h0;
    if (!mode) begin
      if (sw && (ext_cmd <= lim1)) begin
        nxt_limit = ext_cmd;
        nxt_src = 2'h1;
      end
    end else if (sw || (lim2 < lim1)) begin
      nxt_limit = lim2;
      nxt_src = 2'h2;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      limit_ff <= '0;
      src_ff <= 2'h0;
    end else if (ce) begin
      limit_ff <= nxt_limit;
      src_ff <= nxt_src;
    end
  end
endmodule // sis_torque_sel

// >>> logic/sis_top.sv
// Purpose: input signal selection of a servo amplifier
// Assumes: one clock, synchronous active-high reset, pins synchronous to CLK
// Notes: selection words are held in registers reached over a plain port
//
// Notes on behaviour
// - servo-on follows its pin when its selection is 0 and is forced on when 1.
// - forward limit follows its pin when its selection is 0 and is forced on when 1.
// - reverse limit follows its pin when its selection is 0 and is forced on when 1.
// - in mode 0 an active switch applies the external command unless limit 1 is smaller.
// - in mode 1 the switch picks limit 2 or 1, and a smaller limit 2 always applies.
// - the function word's selection 1 gives an input the second accel/decel function.
// - both words reset to 0000 and take only 0000 to 1111h, each digit 0 or 1.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
module sis_top #(
  parameter int TRQ_W = sis_pkg::TRQ_W
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic [sis_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sis_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [sis_pkg::DATA_W-1:0] RDATA,
  input wire sis_pkg::sis_pins_type PINS,
  input wire logic [TRQ_W-1:0] EXT_TORQUE_CMD,
  output logic SERVO_ON,
  output logic FWD_LIMIT,
  output logic REV_LIMIT,
  output logic ACCEL2_SEL,
  output logic [TRQ_W-1:0] TORQUE_LIMIT,
  output logic [1:0] TORQUE_SRC
);
  logic [15:0] func_sel_ff;
  logic [15:0] src_sel_ff;
  logic [TRQ_W-1:0] lim1_ff;
  logic [TRQ_W-1:0] lim2_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  sis_pkg::sis_src_type src;

  // selection words: bits outside one per digit are dropped on write
  always_ff @(posedge CLK) begin
    if (SRST) begin
      func_sel_ff <= sis_pkg::RST_SEL;
      src_sel_ff <= sis_pkg::RST_SEL;
      lim1_ff <= TRQ_W'(sis_pkg::RST_LIMIT);
      lim2_ff <= TRQ_W'(sis_pkg::RST_LIMIT);
    end else if (CE && WR) begin
      unique case (ADDR)
        sis_pkg::OFF_FUNC_SEL: begin
          func_sel_ff <= WDATA & sis_pkg::SEL_MASK;
        end
        sis_pkg::OFF_SRC_SEL: begin
          src_sel_ff <= WDATA & sis_pkg::SEL_MASK;
        end
        sis_pkg::OFF_LIMIT1: begin
          lim1_ff <= WDATA[TRQ_W-1:0];
        end
        sis_pkg::OFF_LIMIT2: begin
          lim2_ff <= WDATA[TRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // one selection per digit
  always_comb begin
    src.trq_mode = src_sel_ff[sis_pkg::SRC_TRQMODE_POS];
    src.servo_auto = src_sel_ff[sis_pkg::SRC_SERVO_POS];
    src.fwd_auto = src_sel_ff[sis_pkg::SRC_FWD_POS];
    src.rev_auto = src_sel_ff[sis_pkg::SRC_REV_POS];
  end

  sis_src_pick u_servo (
    .clk(CLK), .srst(SRST), .ce(CE),
    .force_on(src.servo_auto), .pin(PINS.servo_on_input), .state_ff(SERVO_ON)
  );
  sis_src_pick u_fwd (
    .clk(CLK), .srst(SRST), .ce(CE),
    .force_on(src.fwd_auto), .pin(PINS.forward_limit_input), .state_ff(FWD_LIMIT)
  );
  sis_src_pick u_rev (
    .clk(CLK), .srst(SRST), .ce(CE),
    .force_on(src.rev_auto), .pin(PINS.reverse_limit_input), .state_ff(REV_LIMIT)
  );
  // an accel2 pin without its function assigned is ignored
  sis_src_pick u_acc (
    .clk(CLK), .srst(SRST), .ce(CE),
    .force_on(1'b0),
    .pin(PINS.accel2_input & func_sel_ff[sis_pkg::FUNC_ACCEL2_POS]),
    .state_ff(ACCEL2_SEL)
  );

  sis_torque_sel #(.W(TRQ_W)) u_trq (
    .clk(CLK), .srst(SRST), .ce(CE),
    .mode(src.trq_mode), .sw(PINS.torque_limit_switch),
    .ext_cmd(EXT_TORQUE_CMD), .lim1(lim1_ff), .lim2(lim2_ff),
    .limit_ff(TORQUE_LIMIT), .src_ff(TORQUE_SRC)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (ADDR)
      sis_pkg::OFF_FUNC_SEL: nxt_rdata = func_sel_ff;
      sis_pkg::OFF_SRC_SEL: nxt_rdata = src_sel_ff;
      sis_pkg::OFF_LIMIT1: nxt_rdata = 16'(lim1_ff);
      sis_pkg::OFF_LIMIT2: nxt_rdata = 16'(lim2_ff);
      sis_pkg::OFF_STATUS: begin
        nxt_rdata[sis_pkg::ST_SERVO] = SERVO_ON;
        nxt_rdata[sis_pkg::ST_FWD] = FWD_LIMIT;
        nxt_rdata[sis_pkg::ST_REV] = REV_LIMIT;
        nxt_rdata[sis_pkg::ST_ACCEL2] = ACCEL2_SEL;
        nxt_rdata[sis_pkg::ST_TRQSEL +: 2] = TORQUE_SRC;
      end
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_ff <= 16'h0000;
    end else if (CE) begin
      rdata_ff <= (RD) ? nxt_rdata : 16'h0000;
    end
  end
  assign RDATA = rdata_ff;

  // checks
  chk_servo_force: assert property (@(posedge CLK) disable iff (SRST)
    (CE && src.servo_auto) |=> SERVO_ON)
    else $error("servo-on not forced");
  chk_servo_follow: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !src.servo_auto) |=> (SERVO_ON == $past(PINS.servo_on_input)))
    else $error("servo-on not following pin");
  chk_fwd_limit: assert property (@(posedge CLK) disable iff (SRST)
    CE |=> (FWD_LIMIT == ($past(src.fwd_auto) | $past(PINS.forward_limit_input))))
    else $error("forward limit wrong");
  chk_rev_limit: assert property (@(posedge CLK) disable iff (SRST)
    CE |=> (REV_LIMIT == ($past(src.rev_auto) | $past(PINS.reverse_limit_input))))
    else $error("reverse limit wrong");
  chk_trq_mode0: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !src.trq_mode && !PINS.torque_limit_switch)
    |=> (TORQUE_LIMIT == $past(lim1_ff) && TORQUE_SRC == 2'h0))
    else $error("mode 0 idle limit not limit 1");
  chk_trq_ext: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !src.trq_mode && PINS.torque_limit_switch && EXT_TORQUE_CMD < lim1_ff)
    |=> (TORQUE_LIMIT == $past(EXT_TORQUE_CMD) && TORQUE_SRC == 2'h1))
    else $error("external limit not applied");
  chk_trq_cap: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !src.trq_mode && PINS.torque_limit_switch && EXT_TORQUE_CMD > lim1_ff)
    |=> (TORQUE_LIMIT == $past(lim1_ff) && TORQUE_SRC == 2'h0))
    else $error("external limit above limit 1 applied");
  chk_trq_mode1: assert property (@(posedge CLK) disable iff (SRST)
    (CE && src.trq_mode && (PINS.torque_limit_switch || lim2_ff < lim1_ff))
    |=> (TORQUE_LIMIT == $past(lim2_ff) && TORQUE_SRC == 2'h2))
    else $error("limit 2 not applied");
  chk_trq_idle1: assert property (@(posedge CLK) disable iff (SRST)
    (CE && src.trq_mode && !PINS.torque_limit_switch && !(lim2_ff < lim1_ff))
    |=> (TORQUE_LIMIT == $past(lim1_ff) && TORQUE_SRC == 2'h0))
    else $error("mode 1 idle limit not limit 1");
  chk_accel2_gate: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !func_sel_ff[sis_pkg::FUNC_ACCEL2_POS]) |=> !ACCEL2_SEL)
    else $error("accel2 active while unassigned");
  chk_accel2_follow: assert property (@(posedge CLK) disable iff (SRST)
    (CE && func_sel_ff[sis_pkg::FUNC_ACCEL2_POS])
    |=> (ACCEL2_SEL == $past(PINS.accel2_input)))
    else $error("accel2 not following pin");
  chk_sel_range: assert property (@(posedge CLK) disable iff (SRST)
    ((src_sel_ff & ~sis_pkg::SEL_MASK) == 16'h0000)
    && ((func_sel_ff & ~sis_pkg::SEL_MASK) == 16'h0000))
    else $error("selection word out of range");
  chk_sel_digit: assert property (@(posedge CLK) disable iff (SRST)
    (CE && WR && ADDR == sis_pkg::OFF_SRC_SEL)
    |=> (src_sel_ff == ($past(WDATA) & sis_pkg::SEL_MASK)))
    else $error("selection digits not stored");
  chk_read_data: assert property (@(posedge CLK) disable iff (SRST)
    (CE && RD && ADDR == sis_pkg::OFF_FUNC_SEL) |=> (RDATA == $past(func_sel_ff)))
    else $error("read data wrong");
  chk_read_idle: assert property (@(posedge CLK) disable iff (SRST)
    (CE && !RD) |=> (RDATA == 16'h0000))
    else $error("read data without a read strobe");
  // a low enable must hold every register, outputs and settings alike
  chk_ce_freeze: assert property (@(posedge CLK) disable iff (SRST)
    !CE |=> ($stable(SERVO_ON) && $stable(TORQUE_LIMIT) && $stable(src_sel_ff)))
    else $error("state moved while enable low");

  cov_servo_auto: cover property (@(posedge CLK) disable iff (SRST)
    src.servo_auto && !PINS.servo_on_input ##1 SERVO_ON);
  cov_trq_ext: cover property (@(posedge CLK) disable iff (SRST) TORQUE_SRC == 2'h1);
  cov_trq_lim2: cover property (@(posedge CLK) disable iff (SRST)
    src.trq_mode && !PINS.torque_limit_switch ##1 TORQUE_SRC == 2'h2);
  cov_accel2: cover property (@(posedge CLK) disable iff (SRST) ACCEL2_SEL);
endmodule // sis_top

// >>> testbench/sis_ctrl_model.sv
// Purpose: controller side that drives the discrete input lines
// Assumes: commanded levels reach the lines one cycle later
// Notes: plain levels, no contact bounce modelled
module sis_ctrl_model (
  input wire logic clk,
  input wire sis_pkg::sis_pins_type pin_cmd,
  input wire logic [7:0] ext_cmd,
  output sis_pkg::sis_pins_type pins_ff = '0,
  output logic [7:0] ext_ff = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered so a line never changes in the edge that samples it
  always @(posedge clk) begin
    pins_ff <= pin_cmd;
    ext_ff <= ext_cmd;
  end
endmodule // sis_ctrl_model

// >>> testbench/tb_sis_top.sv
// Purpose: self-checking bench for the input signal select block
// Assumes: outputs settle one cycle after their cause
// Notes: rows cover the selection cases, hand tests cover reset and masking
module tb_sis_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] fn, src;
    logic [7:0] l1, l2, ext;
    logic [4:0] pin;
    logic [3:0] eo;
    logic [7:0] el;
    logic [1:0] es;
  } sis_row_type;
  // eo is servo, forward, reverse, accel2
  sis_row_type rows[10] = '{
    '{16'h0000, 16'h0000, 8'h64, 8'h32, 8'h10, 5'h00, 4'h0, 8'h64, 2'h0},
    '{16'h0001, 16'h0000, 8'h64, 8'h32, 8'h10, 5'h1F, 4'hF, 8'h10, 2'h1},
    '{16'h0000, 16'h1110, 8'h64, 8'h32, 8'h70, 5'h02, 4'hE, 8'h64, 2'h0},
    '{16'h0001, 16'h0001, 8'h50, 8'h30, 8'h10, 5'h03, 4'h1, 8'h30, 2'h2},
    '{16'h0000, 16'h0001, 8'h20, 8'h30, 8'h10, 5'h00, 4'h0, 8'h20, 2'h0},
    '{16'h0000, 16'h0001, 8'h40, 8'h30, 8'h10, 5'h00, 4'h0, 8'h30, 2'h2},
    '{16'h0000, 16'h0001, 8'h20, 8'h30, 8'h10, 5'h02, 4'h0, 8'h30, 2'h2},
    '{16'h0000, 16'h0100, 8'h20, 8'h30, 8'h10, 5'h0C, 4'h6, 8'h20, 2'h0},
    '{16'h0000, 16'h0000, 8'h40, 8'h30, 8'h40, 5'h02, 4'h0, 8'h40, 2'h1},
    '{16'h0000, 16'h0000, 8'h64, 8'h30, 8'h10, 5'h01, 4'h0, 8'h64, 2'h0}};
  logic CLK = 1'b0, SRST = 1'b1, CE = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, RDATA, rd_val;
  sis_pkg::sis_pins_type PINS, pin_cmd = '0;
  logic [7:0] EXT_TORQUE_CMD, ext_cmd = 8'h00, TORQUE_LIMIT;
  logic SERVO_ON, FWD_LIMIT, REV_LIMIT, ACCEL2_SEL;
  logic [1:0] TORQUE_SRC;
  int bad_count = 0, cmp_count = 0;

  always #20 CLK = ~CLK;

  sis_ctrl_model u_ctrl (.clk(CLK), .pin_cmd(pin_cmd), .ext_cmd(ext_cmd), .pins_ff(PINS),
    .ext_ff(EXT_TORQUE_CMD));
  sis_top u_dut (.CLK(CLK), .SRST(SRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .PINS(PINS), .EXT_TORQUE_CMD(EXT_TORQUE_CMD),
    .SERVO_ON(SERVO_ON), .FWD_LIMIT(FWD_LIMIT), .REV_LIMIT(REV_LIMIT),
    .ACCEL2_SEL(ACCEL2_SEL), .TORQUE_LIMIT(TORQUE_LIMIT), .TORQUE_SRC(TORQUE_SRC));

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    rd_val = RDATA;
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge CLK);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    #1;
    chk_bit("servo in reset", 1'b0, SERVO_ON);
    rd(sis_pkg::OFF_FUNC_SEL);
    chk_word("func reset", 16'h0000, rd_val);
    rd(sis_pkg::OFF_SRC_SEL);
    chk_word("src reset", 16'h0000, rd_val);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(sis_pkg::OFF_FUNC_SEL, rows[i].fn);
      wr(sis_pkg::OFF_SRC_SEL, rows[i].src);
      wr(sis_pkg::OFF_LIMIT1, {8'h00, rows[i].l1});
      wr(sis_pkg::OFF_LIMIT2, {8'h00, rows[i].l2});
      pin_cmd <= rows[i].pin;
      ext_cmd <= rows[i].ext;
      repeat (3) @(posedge CLK);
      #1;
      chk_bit("servo", rows[i].eo[3], SERVO_ON);
      chk_bit("forward", rows[i].eo[2], FWD_LIMIT);
      chk_bit("reverse", rows[i].eo[1], REV_LIMIT);
      chk_bit("accel2", rows[i].eo[0], ACCEL2_SEL);
      chk_word("limit", {8'h00, rows[i].el}, {8'h00, TORQUE_LIMIT});
      chk_word("limit src", {14'h0000, rows[i].es}, {14'h0000, TORQUE_SRC});
      $display("row %0d done", i);
    end
    pin_cmd <= '0;
    wr(sis_pkg::OFF_SRC_SEL, 16'hFFFF);
    rd(sis_pkg::OFF_SRC_SEL);
    chk_word("src masked", 16'h1111, rd_val);
    @(posedge CLK);
    #1;
    chk_word("rdata idle", 16'h0000, RDATA);
    chk_bit("servo auto", 1'b1, SERVO_ON);
    chk_bit("forward auto", 1'b1, FWD_LIMIT);
    chk_bit("reverse auto", 1'b1, REV_LIMIT);
    // all three lines forced on, mode 1 with limit 2 below limit 1
    rd(sis_pkg::OFF_STATUS);
    chk_word("status", 16'h0027, rd_val);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk_word("unmapped", 16'h0000, rd_val);
    $display("masking test done");
    @(posedge CLK);
    CE <= 1'b0;
    wr(sis_pkg::OFF_SRC_SEL, 16'h0000);
    repeat (2) @(posedge CLK);
    #1;
    chk_bit("servo frozen", 1'b1, SERVO_ON);
    @(posedge CLK);
    CE <= 1'b1;
    rd(sis_pkg::OFF_SRC_SEL);
    chk_word("src frozen", 16'h1111, rd_val);
    $display("clock enable test done");
    @(posedge CLK);
    SRST <= 1'b1;
    @(posedge CLK);
    SRST <= 1'b0;
    rd(sis_pkg::OFF_SRC_SEL);
    chk_word("src second reset", 16'h0000, rd_val);
    chk_bit("servo second reset", 1'b0, SERVO_ON);
    $display("second reset test done");
    final_report();
  end
endmodule // tb_sis_top
